// ---- inc/as_consts.svh ----
// constants of the async serial control and status block
//
// ***************************************************************
// Overview of operation
// - loop bits choose normal, internal loop, single-wire
// - bit 7 gates empty-buffer flag onto interrupt
// - bit 6 gates done flag onto interrupt
// - bit 5 gates full and overrun flags
// - bit 4 gates quiet-line flag onto interrupt
// - tx_on enables transmitter; toggle queues preamble
// - rx_on enables or disables the receiver
// - rx_sleep parks receiver; hardware clears on wakeup
// - break_send toggle sends break; held sends more
// - status writes ignored; status always readable
// - empty flag sets on load, clears by sequence
// - done flag low while sending, high when idle
// - done clears by sequence or queueing; clear wins
// - full flag sets on frame, clears by sequence
// - quiet flag after 10 or 11 ones
// - quiet clears by sequence, rearmed by frame
// - no quiet flag while rx_sleep is set
// - nine-bit select sets frame and quiet length
// - long_break_sel picks break length 13/14
// - overrun sets when frame meets full register
// ***************************************************************
`ifndef AS_CONSTS_SVH
`define AS_CONSTS_SVH
// register byte offsets
`define AS_OFF_CTRL1  8'h00
`define AS_OFF_CTRL2  8'h04
`define AS_OFF_STAT1  8'h08
`define AS_OFF_DATAL  8'h0C
`define AS_OFF_CTRL3  8'h10
// control one fields
`define AS_C1_LOOP    7
`define AS_C1_SRC     5
`define AS_C1_NINE    4
`define AS_C1_MASK    8'hB0
// control two fields
`define AS_C2_TXE_IE  7
`define AS_C2_DONE_IE 6
`define AS_C2_RXF_IE  5
`define AS_C2_QUIET_IE 4
`define AS_C2_TX_ON   3
`define AS_C2_RX_ON   2
`define AS_C2_SLEEP   1
`define AS_C2_BREAK   0
// control three fields
`define AS_C3_LONGBRK 2
`define AS_C3_TXBIT8  0
`define AS_C3_MASK    8'h05
// status one fields
`define AS_S1_TXE     7
`define AS_S1_DONE    6
`define AS_S1_RXF     5
`define AS_S1_QUIET   4
`define AS_S1_OVR     3
`define AS_S1_MASK    8'hF8
// reset values
`define AS_CTRL_RST   8'h00
`define AS_STAT1_RST  8'hC0
// frame and break lengths in bit times
`define AS_LEN8       4'hA
`define AS_LEN9       4'hB
`define AS_BRK8       4'hA
`define AS_BRK9       4'hB
`define AS_LBRK8      4'hD
`define AS_LBRK9      4'hE
// bus responses
`define AS_RESP_OKAY  2'h0
`define AS_RESP_DEC   2'h3
`endif

// ---- inc/as_pkg.sv ----
// types of the async serial control and status block
package as_pkg;
  typedef enum logic [1:0] {AS_RX_IDLE, AS_RX_START, AS_RX_DATA, AS_RX_STOP} as_rx_st_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } as_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } as_axi_rsp_t;
  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  ctrl3;
    logic [7:0]  stat1;
    logic [7:0]  armed;
    logic        quiet_ok;
    logic [7:0]  tx_buf;
    logic        tx_busy;
    logic [13:0] tx_shift;
    logic [3:0]  tx_left;
    logic [15:0] tx_cnt;
    logic        pre_pend;
    logic        brk_pend;
    logic [1:0]  rxd_sync;
    logic [1:0]  txd_sync;
    as_rx_st_t   rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bitn;
    logic [8:0]  rx_shift;
    logic [7:0]  rx_data;
    logic [19:0] quiet_cnt;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } as_state_t;
endpackage

// ---- src/as_serial_ctrl.sv ----
// async serial control/status registers with transmitter and receiver
`timescale 1ns/1ps
`include "as_consts.svh"
module as_serial_ctrl #(
  parameter int BIT_CYCLES = 16
) (
  // clock and reset
  input  wire logic               SYS_CLK_I,
  input  wire logic               RST_I,
  // register bus
  input  wire as_pkg::as_axi_req_t AXI_REQ_I,
  output as_pkg::as_axi_rsp_t      AXI_RSP_O,
  // serial line
  input  wire logic               RXD_I,
  input  wire logic               TXD_I,
  output logic                    TXD_O,
  output logic                    TXD_OE_O,
  // interrupt request
  output logic                    IRQ_O
);
  import as_pkg::*;

  // ***************************************************************
  // state and derived signals
  // ***************************************************************
  as_state_t s_reg;
  as_state_t s_next;

  logic [15:0] bit_cyc;
  logic [15:0] half_cyc;
  logic        nine;
  logic [3:0]  frame_len;
  logic [3:0]  brk_len;
  logic [19:0] quiet_lim;
  logic        tx_line;
  logic        tx_int;
  logic        rx_in;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        aw_have;
  logic        w_have;
  logic [7:0]  wr_addr;
  logic [7:0]  rd_val;
  logic        rd_hit;

  // bit timing from the parameter; no baud divider register here
  assign bit_cyc   = 16'(BIT_CYCLES);
  assign half_cyc  = 16'(BIT_CYCLES / 2);

  // frame and break length follow the nine-bit and long-break selects
  assign nine      = s_reg.ctrl1[`AS_C1_NINE];
  assign frame_len = nine ? `AS_LEN9 : `AS_LEN8;
  assign brk_len   = s_reg.ctrl3[`AS_C3_LONGBRK] ?
                     (nine ? `AS_LBRK9 : `AS_LBRK8) :
                     (nine ? `AS_BRK9 : `AS_BRK8);
  assign quiet_lim = 20'(BIT_CYCLES * int'(frame_len));

  // line idles high whenever the shifter is not busy
  assign tx_line  = s_reg.tx_busy ? s_reg.tx_shift[0] : 1'b1;
  assign tx_int   = s_reg.ctrl2[`AS_C2_TX_ON] ? tx_line : 1'b1;

  // receiver source: pin, internal loop, or the tx pin itself
  always_comb begin
    if (!s_reg.ctrl1[`AS_C1_LOOP]) begin
      rx_in = s_reg.rxd_sync[1];
    end else if (s_reg.ctrl1[`AS_C1_SRC]) begin
      rx_in = s_reg.txd_sync[1];
    end else begin
      rx_in = tx_int;
    end
  end

  // ***************************************************************
  // bus handshakes
  // ***************************************************************
  assign aw_hs   = AXI_REQ_I.awvalid & AXI_RSP_O.awready;
  assign w_hs    = AXI_REQ_I.wvalid & AXI_RSP_O.wready;
  assign ar_hs   = AXI_REQ_I.arvalid & AXI_RSP_O.arready;
  assign aw_have = s_reg.aw_got | aw_hs;
  assign w_have  = s_reg.w_got | w_hs;
  assign wr_addr = s_reg.aw_got ? s_reg.aw_addr : AXI_REQ_I.awaddr;

  // read mux; status is readable at any time
  always_comb begin
    rd_hit = 1'b1;
    case ({AXI_REQ_I.araddr[7:2], 2'b00})
      `AS_OFF_CTRL1: rd_val = s_reg.ctrl1;
      `AS_OFF_CTRL2: rd_val = s_reg.ctrl2;
      `AS_OFF_STAT1: rd_val = s_reg.stat1 & `AS_S1_MASK;
      `AS_OFF_DATAL: rd_val = s_reg.rx_data;
      `AS_OFF_CTRL3: rd_val = s_reg.ctrl3;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic [7:0] old_c2;
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic       done_clr;
    logic       done_set;
    logic       wr_go;
    logic [7:0] wd;
    logic       ln;
    logic       queued;
    logic       frame_end;
    logic       quiet_hit;
    old_c2    = s_reg.ctrl2;
    set_f     = 8'h00;
    clr_f     = 8'h00;
    done_clr  = 1'b0;
    done_set  = 1'b0;
    queued    = 1'b0;
    wr_go     = 1'b0;
    wd        = 8'h00;
    ln        = 1'b0;
    frame_end = 1'b0;
    quiet_hit = 1'b0;
    s_next    = s_reg;

    // two-stage synchronisers; only the second stage is read
    s_next.rxd_sync = {s_reg.rxd_sync[0], RXD_I};
    s_next.txd_sync = {s_reg.txd_sync[0], TXD_I};

    // write channel: address and data latched in either order
    if (aw_hs) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = AXI_REQ_I.awaddr;
    end
    if (w_hs) begin
      s_next.w_got   = 1'b1;
      s_next.w_data  = AXI_REQ_I.wdata[7:0];
      s_next.w_lane0 = AXI_REQ_I.wstrb[0];
    end
    wr_go = aw_have & w_have & ~s_reg.bvalid;
    if (s_reg.bvalid && AXI_REQ_I.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      wd = s_reg.w_got ? s_reg.w_data : AXI_REQ_I.wdata[7:0];
      ln = s_reg.w_got ? s_reg.w_lane0 : AXI_REQ_I.wstrb[0];
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = `AS_RESP_OKAY;
      case ({wr_addr[7:2], 2'b00})
        `AS_OFF_CTRL1: if (ln) s_next.ctrl1 = wd & `AS_C1_MASK;
        `AS_OFF_CTRL2: if (ln) s_next.ctrl2 = wd;
        `AS_OFF_CTRL3: if (ln) s_next.ctrl3 = wd & `AS_C3_MASK;
        `AS_OFF_STAT1: ;
        `AS_OFF_DATAL: begin
          if (ln) begin
            s_next.tx_buf = wd;
            // second step of the clear sequence for the tx flags
            clr_f[`AS_S1_TXE] = s_reg.armed[`AS_S1_TXE];
            done_clr          = s_reg.armed[`AS_S1_DONE];
            s_next.armed[`AS_S1_TXE]  = 1'b0;
            s_next.armed[`AS_S1_DONE] = 1'b0;
          end
        end
        default: s_next.bresp = `AS_RESP_DEC;
      endcase
    end

    // 0->1 on tx_on queues a preamble, on break_send a break
    if (~old_c2[`AS_C2_TX_ON] & s_next.ctrl2[`AS_C2_TX_ON]) begin
      s_next.pre_pend = 1'b1;
      queued          = 1'b1;
    end
    if (~old_c2[`AS_C2_BREAK] & s_next.ctrl2[`AS_C2_BREAK]) begin
      s_next.brk_pend = 1'b1;
      queued          = 1'b1;
    end

    // read channel: status read arms, data read completes the clear
    if (s_reg.rvalid && AXI_REQ_I.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = {24'h000000, rd_val};
      s_next.rresp  = rd_hit ? `AS_RESP_OKAY : `AS_RESP_DEC;
      if ({AXI_REQ_I.araddr[7:2], 2'b00} == `AS_OFF_STAT1) begin
        s_next.armed = s_reg.stat1 & `AS_S1_MASK;
      end
      if ({AXI_REQ_I.araddr[7:2], 2'b00} == `AS_OFF_DATAL) begin
        clr_f[`AS_S1_RXF]   = s_reg.armed[`AS_S1_RXF];
        clr_f[`AS_S1_QUIET] = s_reg.armed[`AS_S1_QUIET];
        clr_f[`AS_S1_OVR]   = s_reg.armed[`AS_S1_OVR];
        s_next.armed[`AS_S1_RXF]   = 1'b0;
        s_next.armed[`AS_S1_QUIET] = 1'b0;
        s_next.armed[`AS_S1_OVR]   = 1'b0;
      end
    end

    // transmitter: one bit per BIT_CYCLES, lsb first
    if (s_reg.tx_busy) begin
      if (s_reg.tx_cnt == 16'h0001) begin
        s_next.tx_cnt   = bit_cyc;
        s_next.tx_shift = {1'b1, s_reg.tx_shift[13:1]};
        s_next.tx_left  = s_reg.tx_left - 4'h1;
        if (s_reg.tx_left == 4'h1) begin
          s_next.tx_busy = 1'b0;
        end
      end else begin
        s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
      end
    end else if (s_reg.ctrl2[`AS_C2_TX_ON]) begin
      if (s_reg.brk_pend || s_reg.ctrl2[`AS_C2_BREAK]) begin
        // break of all zeros, repeated while break_send stays set
        s_next.brk_pend = 1'b0;
        s_next.tx_busy  = 1'b1;
        s_next.tx_shift = 14'h0000;
        s_next.tx_left  = brk_len;
        s_next.tx_cnt   = bit_cyc;
      end else if (s_reg.pre_pend) begin
        s_next.pre_pend = 1'b0;
        s_next.tx_busy  = 1'b1;
        s_next.tx_shift = 14'h3FFF;
        s_next.tx_left  = frame_len;
        s_next.tx_cnt   = bit_cyc;
      end else if (!s_reg.stat1[`AS_S1_TXE]) begin
        // shifter takes the byte: buffer empty again
        set_f[`AS_S1_TXE] = 1'b1;
        s_next.tx_busy    = 1'b1;
        s_next.tx_shift   = nine ?
          {4'b1111, s_reg.ctrl3[`AS_C3_TXBIT8], s_reg.tx_buf, 1'b0} :
          {4'b1111, 1'b1, s_reg.tx_buf, 1'b0};
        s_next.tx_left    = frame_len;
        s_next.tx_cnt     = bit_cyc;
        queued            = 1'b1;
      end
    end

    // done flag: low while anything is sent or queued
    done_set = s_reg.stat1[`AS_S1_TXE] & ~s_reg.tx_busy & ~s_reg.pre_pend
               & ~s_reg.brk_pend & ~s_reg.ctrl2[`AS_C2_BREAK];
    if (s_reg.tx_busy || queued) begin
      done_clr = 1'b1;
    end

    // receiver: start check at mid bit, then sample each bit time
    if (!s_reg.ctrl2[`AS_C2_RX_ON]) begin
      s_next.rx_st     = AS_RX_IDLE;
      s_next.quiet_cnt = 20'h00000;
    end else begin
      case (s_reg.rx_st)
        AS_RX_IDLE: begin
          if (!rx_in) begin
            s_next.rx_st  = AS_RX_START;
            s_next.rx_cnt = half_cyc;
          end
        end
        AS_RX_START: begin
          if (s_reg.rx_cnt == 16'h0001) begin
            s_next.rx_st   = rx_in ? AS_RX_IDLE : AS_RX_DATA;
            s_next.rx_cnt  = bit_cyc;
            s_next.rx_bitn = 4'h0;
          end else begin
            s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
          end
        end
        AS_RX_DATA: begin
          if (s_reg.rx_cnt == 16'h0001) begin
            s_next.rx_cnt   = bit_cyc;
            s_next.rx_shift = {rx_in, s_reg.rx_shift[8:1]};
            s_next.rx_bitn  = s_reg.rx_bitn + 4'h1;
            if (s_reg.rx_bitn == frame_len - 4'h3) begin
              s_next.rx_st = AS_RX_STOP;
            end
          end else begin
            s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
          end
        end
        AS_RX_STOP: begin
          if (s_reg.rx_cnt == 16'h0001) begin
            s_next.rx_st = AS_RX_IDLE;
            frame_end    = 1'b1;
          end else begin
            s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
          end
        end
        default: s_next.rx_st = AS_RX_IDLE;
      endcase

      // a run of ones one frame long is a quiet line
      if (!rx_in) begin
        s_next.quiet_cnt = 20'h00000;
      end else if (s_reg.quiet_cnt != quiet_lim) begin
        s_next.quiet_cnt = s_reg.quiet_cnt + 20'h00001;
        quiet_hit        = (s_reg.quiet_cnt + 20'h00001) == quiet_lim;
      end
    end

    // frames in standby are dropped; a full register means overrun
    if (frame_end && !s_reg.ctrl2[`AS_C2_SLEEP]) begin
      if (s_reg.stat1[`AS_S1_RXF]) begin
        set_f[`AS_S1_OVR] = 1'b1;
      end else begin
        set_f[`AS_S1_RXF] = 1'b1;
        s_next.rx_data    = nine ? s_reg.rx_shift[7:0] : s_reg.rx_shift[8:1];
        s_next.quiet_ok   = 1'b1;
      end
    end

    // quiet line wakes a sleeping receiver instead of flagging
    if (quiet_hit) begin
      if (s_reg.ctrl2[`AS_C2_SLEEP]) begin
        s_next.ctrl2[`AS_C2_SLEEP] = 1'b0;
      end else if (s_reg.quiet_ok) begin
        set_f[`AS_S1_QUIET] = 1'b1;
      end
    end
    if (clr_f[`AS_S1_QUIET]) begin
      s_next.quiet_ok = set_f[`AS_S1_RXF];
    end

    // set beats clear for every flag except done, where clear wins
    s_next.stat1 = ((s_reg.stat1 & ~clr_f) | set_f) & `AS_S1_MASK;
    s_next.stat1[`AS_S1_DONE] = done_clr ? 1'b0 :
                                (done_set | s_reg.stat1[`AS_S1_DONE]);
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      s_reg          <= '0;
      s_reg.ctrl1    <= `AS_CTRL_RST;
      s_reg.ctrl2    <= `AS_CTRL_RST;
      s_reg.ctrl3    <= `AS_CTRL_RST;
      s_reg.stat1    <= `AS_STAT1_RST;
      s_reg.rxd_sync <= 2'b11;
      s_reg.txd_sync <= 2'b11;
      s_reg.tx_shift <= 14'h3FFF;
      s_reg.rx_st    <= AS_RX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign AXI_RSP_O.awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign AXI_RSP_O.wready  = ~s_reg.w_got & ~s_reg.bvalid;
  assign AXI_RSP_O.bvalid  = s_reg.bvalid;
  assign AXI_RSP_O.bresp   = s_reg.bresp;
  assign AXI_RSP_O.arready = ~s_reg.rvalid;
  assign AXI_RSP_O.rvalid  = s_reg.rvalid;
  assign AXI_RSP_O.rdata   = s_reg.rdata;
  assign AXI_RSP_O.rresp   = s_reg.rresp;

  // pin handed to the serial logic only while the transmitter is on
  assign TXD_O    = tx_int;
  assign TXD_OE_O = s_reg.ctrl2[`AS_C2_TX_ON];

  // receiver requests are held off during standby
  assign IRQ_O = (s_reg.stat1[`AS_S1_TXE] & s_reg.ctrl2[`AS_C2_TXE_IE])
               | (s_reg.stat1[`AS_S1_DONE] & s_reg.ctrl2[`AS_C2_DONE_IE])
               | ((s_reg.stat1[`AS_S1_RXF] | s_reg.stat1[`AS_S1_OVR])
                  & s_reg.ctrl2[`AS_C2_RXF_IE] & ~s_reg.ctrl2[`AS_C2_SLEEP])
               | (s_reg.stat1[`AS_S1_QUIET] & s_reg.ctrl2[`AS_C2_QUIET_IE]
                  & ~s_reg.ctrl2[`AS_C2_SLEEP]);
endmodule

// ---- tb/as_peer.sv ----
// remote serial transceiver: drives frames, watches the tx pin
`timescale 1ns/1ps
module as_peer #(
  parameter int BT = 4
) (
  // clock and line
  input  wire logic  clk_i,
  input  wire logic  pin_i,
  // driven lines, idle high like a pulled-up wire
  output logic       rxd_o,
  output logic       txin_o,
  // what was seen on the tx pin
  output logic [7:0] rx_byte_o,
  output int         low_run_o
);
  int         run;
  logic [7:0] b;
  initial begin
    rxd_o = 1'b1;
    txin_o = 1'b1;
    run = 0;
    low_run_o = 0;
    rx_byte_o = 8'h00;
  end
  // one frame: start low, eight bits lsb first, stop high
  task automatic send(input bit sw, input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      if (sw) txin_o <= f[i];
      else rxd_o <= f[i];
      repeat (BT - 1) @(posedge clk_i);
    end
  endtask
  // length of the last low stretch, taken when the line rises
  always @(posedge clk_i) begin
    if (!pin_i) run <= run + 1;
    else begin
      if (run != 0) low_run_o <= run;
      run <= 0;
    end
  end
  // byte capture sampled mid bit; a break yields a junk byte
  initial forever begin
    @(negedge pin_i);
    repeat (BT / 2) @(posedge clk_i);
    if (!pin_i) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BT) @(posedge clk_i);
        b[i] = pin_i;
      end
      repeat (BT) @(posedge clk_i);
      rx_byte_o = b;
    end
  end
endmodule

// ---- tb/as_serial_ctrl_sva.sv ----
// bus and pin relations of the async serial block
`timescale 1ns/1ps
`include "as_consts.svh"
module as_serial_ctrl_sva (
  // clock and reset
  input wire logic                SYS_CLK_I,
  input wire logic                RST_I,
  // register bus
  input wire as_pkg::as_axi_req_t AXI_REQ_I,
  input wire as_pkg::as_axi_rsp_t AXI_RSP_O,
  // serial line and interrupt
  input wire logic                RXD_I,
  input wire logic                TXD_I,
  input wire logic                TXD_O,
  input wire logic                TXD_OE_O,
  input wire logic                IRQ_O
);
  import as_pkg::*;
  as_axi_req_t q;
  as_axi_rsp_t p;
  logic        wr_go;
  logic        c2_go;
  // both write channels taken on one edge, lane 0 enabled
  assign q     = AXI_REQ_I;
  assign p     = AXI_RSP_O;
  assign wr_go = q.awvalid && p.awready && q.wvalid && p.wready && q.wstrb[0];
  assign c2_go = wr_go && q.awaddr == `AS_OFF_CTRL2;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  wr_answer_a: assert property (q.awvalid && p.awready && q.wvalid && p.wready |=> p.bvalid)
    else $error("write answer missing");
  rd_answer_a: assert property (q.arvalid && p.arready |=> p.rvalid && !p.arready)
    else $error("read answer missing");
  rd_hold_a: assert property (p.rvalid && !q.rready |=> p.rvalid && $stable(p.rdata))
    else $error("read data dropped early");
  wr_hold_a: assert property (p.bvalid && !q.bready |=> p.bvalid && $stable(p.bresp))
    else $error("write answer dropped early");
  pin_idle_a: assert property (!TXD_OE_O |-> TXD_O)
    else $error("tx pin low while released");
  tx_grant_a: assert property (c2_go && q.wdata[`AS_C2_TX_ON] |-> ##[1:2] TXD_OE_O)
    else $error("tx pin not taken");
  tx_drop_a: assert property (c2_go && !q.wdata[`AS_C2_TX_ON] |-> ##[1:2] !TXD_OE_O)
    else $error("tx pin not released");
  stat_wr_a: assert property (wr_go && q.awaddr == `AS_OFF_STAT1 |=> p.bresp == 2'h0)
    else $error("status write refused");
  irq_mask_a: assert property (c2_go && q.wdata[7:4] == 4'h0 |=> !IRQ_O)
    else $error("request with all enables off");
  irq_sleep_a: assert property (c2_go && q.wdata[7:4] == 4'h2 && q.wdata[1] |=> !IRQ_O)
    else $error("request while receiver asleep");
endmodule

// ---- tb/tb.sv ----
// register-level testbench of the async serial block
`timescale 1ns/1ps
`include "as_consts.svh"
module tb;
  import as_pkg::*;
  localparam int BT = 4;
  logic        clk;
  logic        rst;
  as_axi_req_t req;
  as_axi_rsp_t rsp;
  logic        rxd, txd, txd_oe, txin, irq, pin;
  logic [7:0]  rx_byte, q;
  logic [1:0]  r;
  int          low_run, err_count, checked;
  // tx pin wire: design while enabled, else the peer or pull-up
  assign pin = txd_oe ? txd : txin;
  as_serial_ctrl #(.BIT_CYCLES(BT)) as_serial_ctrl_i (.SYS_CLK_I(clk), .RST_I(rst),
    .AXI_REQ_I(req), .AXI_RSP_O(rsp), .RXD_I(rxd), .TXD_I(pin), .TXD_O(txd),
    .TXD_OE_O(txd_oe), .IRQ_O(irq));
  as_peer #(.BT(BT)) as_peer_i (.clk_i(clk), .pin_i(pin), .rxd_o(rxd), .txin_o(txin),
    .rx_byte_o(rx_byte), .low_run_o(low_run));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one bus transfer; readies and answer taken at the rising edge that moves them
  task automatic bus(input bit w, input logic [7:0] a, d, output logic [7:0] o,
                     output logic [1:0] s);
    bit pa, pw, pb, ta, tw, tr;
    @(posedge clk);
    pa = 1;
    pw = w;
    pb = 1;
    if (w) begin
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'h1;
      req.bready <= 1'b1;
    end else begin
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
    end
    while (pa | pw | pb) begin
      @(posedge clk);
      ta = pa && (w ? rsp.awready : rsp.arready);
      tw = pw && rsp.wready;
      tr = pb && (w ? rsp.bvalid : rsp.rvalid);
      o = rsp.rdata[7:0];
      s = w ? rsp.bresp : rsp.rresp;
      if (ta) begin
        pa = 0;
        req.awvalid <= 1'b0;
        req.arvalid <= 1'b0;
      end
      if (tw) begin
        pw = 0;
        req.wvalid <= 1'b0;
      end
      if (tr) begin
        pb = 0;
        req.bready <= 1'b0;
        req.rready <= 1'b0;
      end
    end
  endtask
  // unmapped places answer with a decode error
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q, r);
    chk({6'h0, r}, a > `AS_OFF_CTRL3 ? 8'h03 : 8'h00);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, q, r);
    chk({6'h0, r}, a > `AS_OFF_CTRL3 ? 8'h03 : 8'h00);
  endtask
  // status read first, then the data write
  task automatic tx(input logic [7:0] d);
    rd(`AS_OFF_STAT1);
    wr(`AS_OFF_DATAL, d);
  endtask
  task note(input string s);
    $display("test %s done", s);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    err_count = 0;
    checked = 0;
    rst = 1'b1;
    req = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`AS_OFF_CTRL2);
    chk(q, 8'h00);
    rd(`AS_OFF_STAT1);
    chk(q, 8'hC0);
    wr(`AS_OFF_STAT1, 8'h00);
    rd(`AS_OFF_STAT1);
    chk(q, 8'hC0);
    rd(8'h20);
    wr(8'h20, 8'hFF);
    note("reset");
    // only the two transmit flags stand after reset
    for (int i = 0; i < 4; i++) begin
      wr(`AS_OFF_CTRL2, 8'h80 >> i);
      chk(8'(irq), 8'(i < 2));
    end
    note("irq");
    wr(`AS_OFF_CTRL2, 8'h08);
    chk(8'(txd_oe), 8'h01);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h40, 8'h00);
    tx(8'hA5);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h80, 8'h00);
    cyc(24 * BT);
    chk(rx_byte, 8'hA5);
    rd(`AS_OFF_STAT1);
    chk(q, 8'hC0);
    note("transmit");
    // one break per toggle, short then long
    for (int i = 0; i < 2; i++) begin
      wr(`AS_OFF_CTRL3, i ? 8'h04 : 8'h00);
      wr(`AS_OFF_CTRL2, 8'h09);
      wr(`AS_OFF_CTRL2, 8'h08);
      rd(`AS_OFF_STAT1);
      chk(q & 8'h40, 8'h00);
      cyc(20 * BT);
      chk(8'(low_run == (i ? 13 : 10) * BT || low_run == (i ? 14 : 11) * BT), 8'h01);
    end
    wr(`AS_OFF_CTRL3, 8'h00);
    note("break");
    wr(`AS_OFF_CTRL2, 8'h20);
    as_peer_i.send(1'b0, 8'h11);
    cyc(BT);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h20, 8'h00);
    wr(`AS_OFF_CTRL2, 8'h04);
    as_peer_i.send(1'b0, 8'h3C);
    cyc(BT);
    chk(8'(irq), 8'h00);
    wr(`AS_OFF_CTRL2, 8'h24);
    chk(8'(irq), 8'h01);
    as_peer_i.send(1'b0, 8'h55);
    cyc(15 * BT);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h38, 8'h38);
    rd(`AS_OFF_DATAL);
    chk(q, 8'h3C);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h38, 8'h00);
    cyc(15 * BT);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h10, 8'h00);
    note("receive");
    // internal loop, then single wire fed by the peer
    wr(`AS_OFF_CTRL1, 8'h80);
    wr(`AS_OFF_CTRL2, 8'h0C);
    tx(8'h5A);
    cyc(24 * BT);
    rd(`AS_OFF_STAT1);
    rd(`AS_OFF_DATAL);
    chk(q, 8'h5A);
    wr(`AS_OFF_CTRL1, 8'hA0);
    wr(`AS_OFF_CTRL2, 8'h04);
    as_peer_i.send(1'b1, 8'hC3);
    cyc(BT);
    rd(`AS_OFF_STAT1);
    rd(`AS_OFF_DATAL);
    chk(q, 8'hC3);
    // nine-bit frame through the internal loop
    wr(`AS_OFF_CTRL1, 8'h90);
    wr(`AS_OFF_CTRL2, 8'h0C);
    tx(8'h96);
    cyc(26 * BT);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h20, 8'h20);
    rd(`AS_OFF_DATAL);
    chk(q, 8'h96);
    note("loop");
    // flush the quiet flag left by the loop frames
    wr(`AS_OFF_CTRL1, 8'h00);
    cyc(15 * BT);
    rd(`AS_OFF_STAT1);
    rd(`AS_OFF_DATAL);
    wr(`AS_OFF_CTRL2, 8'h24);
    as_peer_i.send(1'b0, 8'h00);
    cyc(BT);
    wr(`AS_OFF_CTRL2, 8'h26);
    chk(8'(irq), 8'h00);
    cyc(15 * BT);
    rd(`AS_OFF_CTRL2);
    chk(q, 8'h24);
    rd(`AS_OFF_STAT1);
    chk(q & 8'h10, 8'h00);
    chk(8'(irq), 8'h01);
    note("sleep");
    stop_test();
  end
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("BAD at %0t: run hung", $time);
    stop_test();
  end
endmodule
bind as_serial_ctrl as_serial_ctrl_sva as_serial_ctrl_sva_i (.SYS_CLK_I(SYS_CLK_I),
  .RST_I(RST_I), .AXI_REQ_I(AXI_REQ_I), .AXI_RSP_O(AXI_RSP_O), .RXD_I(RXD_I),
  .TXD_I(TXD_I), .TXD_O(TXD_O), .TXD_OE_O(TXD_OE_O), .IRQ_O(IRQ_O));
